// file: common/fcd_pkg.sv
package fcd_pkg;
    // ************************************************************
    // Register map (byte addresses, one word each)
    // ************************************************************
    localparam logic [7:0] ADDR_INPUT    = 8'h00;
    localparam logic [7:0] ADDR_OUTPUT   = 8'h04;
    localparam logic [7:0] ADDR_CTRL     = 8'h08;
    localparam logic [7:0] ADDR_LENGTH   = 8'h0C;
    localparam logic [7:0] ADDR_TAPBASE  = 8'h10;
    localparam logic [7:0] ADDR_COEFBASE = 8'h14;
    localparam logic [7:0] ADDR_DONE     = 8'h18;
    localparam logic [7:0] ADDR_IRQ_STAT = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h20;
    localparam logic [7:0] ADDR_DMA_DONE = 8'h24;
    // ************************************************************
    // Fields and sizes
    // ************************************************************
    localparam int          DATA_W       = 24;
    localparam int          IN_DEPTH     = 4;
    localparam int          CTRL_EN_BIT  = 0;
    localparam int          DONE_CH0_BIT = 0;
    localparam int          DONE_CH1_BIT = 1;
    localparam int          IRQ_IN_BIT   = 0;
    localparam int          IRQ_OUT_BIT  = 1;
    localparam int          IRQ_CH0_BIT  = 2;
    localparam int          IRQ_CH1_BIT  = 3;
    localparam logic [11:0] LEN_RESET    = 12'h000;
    localparam logic [1:0]  MEM_INDEX_W  = 2'h2;
endpackage

// file: core/fcd_in_mem.sv
module fcd_in_mem
    import fcd_pkg::*;
(
    input  wire logic              pclk,
    input  wire logic              wr_en,
    input  wire logic [1:0]        wr_idx,
    input  wire logic [DATA_W-1:0] wr_data,
    input  wire logic [1:0]        rd_idx,
    output logic      [DATA_W-1:0] rd_data
);
    logic [DATA_W-1:0] mem_q [IN_DEPTH];

    always_ff @(posedge pclk) begin
        if (wr_en) begin
            mem_q[wr_idx] <= wr_data;
        end
        rd_data <= mem_q[rd_idx];
    end
endmodule // fcd_in_mem

// file: core/fcd_top.sv
// Function
// RULE1: Raise input-empty request so channel 0 loads input words.
// RULE2: Channel 0 delivers four words per request, the input depth.
// RULE3: Channel 0 source uses block mode with offset one.
// RULE4: Channel 0 destination stays fixed on the input register.
// RULE5: Channel 0 reads X memory; all filter registers decode in Y I/O.
// RULE6: Raise output-full request whenever a result waits; channel 1 drains.
// RULE7: Channel 1 source fixed, destination post-increments by one.
// RULE8: Channel 1 reads Y I/O space, writes X memory.
// RULE9: Program source, destination, count, offset, then control.
// RULE10: Done status bits 0 and 1 set when channel 0 or 1 completes.
// RULE11: Write length and bases first, then control with enable set.
// RULE12: Writing zero to control places the block in individual reset.
// RULE13: Length register holds filter length minus one.
// RULE14: Block mode counter splits words and blocks minus one.
// RULE15: Single-word counter holds total transfers minus one.
// RULE16: Drop input request when full, output request once read. The code drops the input request as soon as the store is not empty.
// RULE17: In individual reset, requests stay low and nothing processes.
//
// Register access over APB and the placing of the registers were decided locally.
module fcd_top
    import fcd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ch0_last_stored,
    input  wire logic        ch1_last_stored,
    output logic             input_empty_request,
    output logic             output_full_request,
    output logic             irq
);
    // ************************************************************
    // Bus decode
    // ************************************************************
    logic acc;
    logic wr;
    logic rd;
    logic mapped;
    assign acc = psel & penable;
    assign wr  = acc & pwrite;
    assign rd  = acc & ~pwrite;

    function automatic logic is_addr(input logic [7:0] a,
                                     input logic [7:0] ref_a);
        return a == ref_a;
    endfunction

    // Every register sits in the block's own I/O space; the DMA reaches
    // the input and output words through the same decode as software.
    always_comb begin // RULE5
        mapped = paddr <= ADDR_DMA_DONE && paddr[1:0] == 2'h0;
    end

    // ************************************************************
    // Registers and datapath state
    // ************************************************************
    logic              en_q, en_d;
    logic [11:0]       len_q, len_d;
    logic [DATA_W-1:0] tap_q, tap_d, coef_q, coef_d;
    logic [2:0]        fill_q, fill_d;
    logic [1:0]        wix_q, wix_d, rix_q, rix_d;
    logic [1:0]        tapn_q, tapn_d;
    logic [DATA_W-1:0] acc_q, acc_d, res_q, res_d;
    logic              full_q, full_d;
    logic [1:0]        done_q, done_d;
    logic [3:0]        ist_q, ist_d, imask_q, imask_d;
    logic [31:0]       prdata_d;
    logic              req_in_q, req_out_q, irq_q;
    logic [DATA_W-1:0] rd_word;
    logic              in_wr, out_rd, drain;
    logic              in_wr_q;

    assign in_wr  = wr & is_addr(paddr, ADDR_INPUT) & en_q & fill_q < 3'h4;
    assign out_rd = rd & is_addr(paddr, ADDR_OUTPUT) & full_q;
    // A word written at the last edge is not yet in the read register,
    // so it waits one cycle; a full result slot throttles the feed.
    assign drain  = en_q & ~full_q & (fill_q > {2'h0, in_wr_q});

    fcd_in_mem u_mem (
        .pclk    (pclk),
        .wr_en   (in_wr),
        .wr_idx  (wix_q),
        .wr_data (pwdata[DATA_W-1:0]),
        .rd_idx  (rix_d),
        .rd_data (rd_word)
    );

    always_comb begin
        en_d    = en_q;
        len_d   = len_q;
        tap_d   = tap_q;
        coef_d  = coef_q;
        imask_d = imask_q;
        fill_d  = fill_q;
        wix_d   = wix_q;
        rix_d   = rix_q;
        tapn_d  = tapn_q;
        acc_d   = acc_q;
        res_d   = res_q;
        full_d  = full_q;
        done_d  = done_q;
        ist_d   = ist_q;
        if (wr & is_addr(paddr, ADDR_LENGTH)) begin // RULE13
            len_d = pwdata[11:0];
        end
        if (wr & is_addr(paddr, ADDR_TAPBASE)) begin
            tap_d = pwdata[DATA_W-1:0];
        end
        if (wr & is_addr(paddr, ADDR_COEFBASE)) begin
            coef_d = pwdata[DATA_W-1:0];
        end
        if (wr & is_addr(paddr, ADDR_IRQ_MASK)) begin
            imask_d = pwdata[3:0];
        end
        if (in_wr) begin // RULE2
            wix_d = wix_q + 2'h1;
        end
        if (drain) begin
            rix_d = rix_q + 2'h1;
        end
        fill_d = fill_q + {2'h0, in_wr} - {2'h0, drain};
        // Simple running accumulate; the arithmetic itself is a stand-in.
        if (drain) begin
            acc_d = acc_q + rd_word;
            if (tapn_q == len_q[1:0]) begin
                res_d  = acc_q + rd_word;
                full_d = 1'b1; // RULE6
                acc_d  = '0;
                tapn_d = 2'h0;
            end else begin
                tapn_d = tapn_q + 2'h1;
            end
        end
        if (out_rd) begin // RULE16
            full_d = 1'b0;
        end
        if (wr & is_addr(paddr, ADDR_DONE)) begin
            done_d = done_q & ~pwdata[1:0];
        end
        // Completion set wins over a clear in the same cycle.
        if (ch0_last_stored) begin // RULE10
            done_d[DONE_CH0_BIT] = 1'b1;
        end
        if (ch1_last_stored) begin // RULE10
            done_d[DONE_CH1_BIT] = 1'b1;
        end
        if (wr & is_addr(paddr, ADDR_IRQ_STAT)) begin
            ist_d = ist_q & ~pwdata[3:0];
        end
        ist_d = ist_d | {ch1_last_stored, ch0_last_stored,
                         req_out_q, req_in_q};
        if (wr & is_addr(paddr, ADDR_CTRL)) begin // RULE11
            en_d = pwdata[CTRL_EN_BIT];
            if (pwdata == 32'h0000_0000) begin // RULE12
                fill_d = 3'h0;
                wix_d  = 2'h0;
                rix_d  = 2'h0;
                tapn_d = 2'h0;
                acc_d  = '0;
                full_d = 1'b0;
            end
        end
    end

    always_comb begin
        prdata_d = 32'h0000_0000;
        // Read data is taken in the setup cycle so it stands with pready.
        if (psel & ~penable & ~pwrite) begin
            unique case (paddr)
                ADDR_OUTPUT:   prdata_d[DATA_W-1:0] = res_q;
                ADDR_CTRL:     prdata_d[0] = en_q;
                ADDR_LENGTH:   prdata_d[11:0] = len_q;
                ADDR_TAPBASE:  prdata_d[DATA_W-1:0] = tap_q;
                ADDR_COEFBASE: prdata_d[DATA_W-1:0] = coef_q;
                ADDR_DONE:     prdata_d[1:0] = done_q;
                ADDR_IRQ_STAT: prdata_d[3:0] = ist_q;
                ADDR_IRQ_MASK: prdata_d[3:0] = imask_q;
                ADDR_DMA_DONE: prdata_d[2:0] = fill_q;
                default:       prdata_d = 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // State registers
    // ************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 1'b0;
            len_q     <= LEN_RESET;
            tap_q     <= '0;
            coef_q    <= '0;
            imask_q   <= 4'h0;
            fill_q    <= 3'h0;
            wix_q     <= 2'h0;
            rix_q     <= 2'h0;
            tapn_q    <= 2'h0;
            acc_q     <= '0;
            res_q     <= '0;
            full_q    <= 1'b0;
            done_q    <= 2'h0;
            ist_q     <= 4'h0;
            prdata    <= 32'h0000_0000;
            pready    <= 1'b0;
            pslverr   <= 1'b0;
            req_in_q  <= 1'b0;
            req_out_q <= 1'b0;
            irq_q     <= 1'b0;
            in_wr_q   <= 1'b0;
        end else begin
            en_q      <= en_d;
            len_q     <= len_d;
            tap_q     <= tap_d;
            coef_q    <= coef_d;
            imask_q   <= imask_d;
            fill_q    <= fill_d;
            wix_q     <= wix_d;
            rix_q     <= rix_d;
            tapn_q    <= tapn_d;
            acc_q     <= acc_d;
            res_q     <= res_d;
            full_q    <= full_d;
            done_q    <= done_d;
            ist_q     <= ist_d;
            prdata    <= prdata_d;
            pready    <= psel & ~penable;
            pslverr   <= psel & ~penable & ~mapped;
            // Request only when the store is wholly empty, so each DMA
            // burst of four always finds room.
            req_in_q  <= en_d & fill_d == 3'h0; // RULE1 RULE17
            req_out_q <= en_d & full_d; // RULE6 RULE17
            irq_q     <= |(ist_d & imask_d);
            in_wr_q   <= in_wr;
        end
    end

    assign input_empty_request = req_in_q;
    assign output_full_request = req_out_q;
    assign irq                 = irq_q;
endmodule // fcd_top

// file: verif/fcd_checker.sv
module fcd_checker
    import fcd_pkg::*;
(
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        input_empty_request,
    input wire logic        output_full_request
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence clear_s;
        pready && pwrite && paddr == ADDR_CTRL && pwdata == 32'h0;
    endsequence
    sequence drain_s;
        pready && !pwrite && paddr == ADDR_OUTPUT && output_full_request;
    endsequence
    chk_ready_access: assert property (psel && !penable |=> pready)
        else $error("no pready in access");
    chk_ready_phase: assert property (pready |-> psel && penable)
        else $error("stray pready");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready held");
    chk_err_unmapped: assert property (
        pready && paddr > ADDR_DMA_DONE |-> pslverr) else $error("no pslverr");
    chk_err_mapped: assert property (
        pready && paddr <= ADDR_DMA_DONE && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("stray pslverr");
    chk_upper_zero: assert property (
        pready && !pwrite && !pslverr |-> prdata[31:DATA_W] == '0)
        else $error("upper bits set");
    chk_clear_quiet: assert property (
        clear_s |=> !input_empty_request && !output_full_request)
        else $error("request after clear");
    chk_drain_drop: assert property (
        drain_s |=> !output_full_request) else $error("request held");
endmodule // fcd_checker

// file: verif/fcd_dma_model.sv
module fcd_dma_model
    import fcd_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        go,
    input  wire logic [3:0]  lag,
    input  wire logic [23:0] count0,
    input  wire logic [11:0] count1,
    input  wire logic        input_empty_request,
    input  wire logic        output_full_request,
    input  wire logic        pready,
    input  wire logic [31:0] prdata,
    output logic      [42:0] bus,
    output logic             ch0_last_stored,
    output logic             ch1_last_stored,
    output logic             fin
);
    logic [31:0] res [16];
    int          src, dst, blk;
    // Released lines show inverted data so a stale value cannot pass.
    task automatic xfer(input logic w, input logic [7:0] a, input int d);
        bus <= {2'h2, w, a, 32'(d)};
        @(posedge pclk);
        bus[41] <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w) res[dst] = prdata;
        bus <= {3'h0, ~bus[39:0]};
        repeat (lag + 1) @(posedge pclk);
    endtask
    initial begin
        bus = '0;
        {ch0_last_stored, ch1_last_stored, fin} = 3'h0;
        forever begin
            @(posedge pclk);
            {ch0_last_stored, ch1_last_stored} <= 2'h0;
            if (!go) begin
                src = 0;
                dst = 0;
                blk = 0;
                foreach (res[i]) res[i] = '1;
            end else if (output_full_request && dst <= count1) begin
                xfer(1'b0, ADDR_OUTPUT, 0);
                dst++;
                ch1_last_stored <= dst > count1;
            end else if (input_empty_request
                         && blk <= count0[23:12]) begin
                for (int k = 0; k <= count0[11:0]; k++) begin
                    xfer(1'b1, ADDR_INPUT, src + 1);
                    src++;
                end
                blk++;
                ch0_last_stored <= blk > count0[23:12];
            end
            fin <= go && dst > count1 && blk > count0[23:12];
        end
    end
endmodule // fcd_dma_model

// file: verif/fcd_top_test.sv
module fcd_top_test import fcd_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn, go, psel, penable, pwrite, pready, pslverr, irq, e;
    logic        ch0_last_stored, ch1_last_stored, fin;
    logic        input_empty_request, output_full_request;
    logic [3:0]  lag;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, r;
    logic [42:0] t_bus, d_bus;
    int          num_errors = 0, comparisons = 0;
    // The model owns the bus only while go is high, so masters never clash.
    assign {psel, penable, pwrite, paddr, pwdata} = go ? d_bus : t_bus;
    always #12.5 pclk = ~pclk;
    fcd_top i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .ch0_last_stored,
        .ch1_last_stored, .input_empty_request, .output_full_request, .irq);
    fcd_dma_model i_dma (.pclk, .go, .lag, .count0(24'h001003),
        .count1(12'h001), .input_empty_request, .output_full_request,
        .pready, .prdata, .bus(d_bus), .ch0_last_stored, .ch1_last_stored,
        .fin);
    task automatic check(input string n, input logic [31:0] x, g);
        comparisons++;
        if (g !== x) begin
            num_errors++;
            $display("unexpected %s: expected %h, seen %h", n, x, g);
        end
    endtask
    task automatic tally_and_finish;
        $display("%0d comparisons, %0d mismatches", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wait_hi(ref logic s, input int lim);
        int n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (s !== 1'b1 && n < lim);
        if (s !== 1'b1) begin
            num_errors++;
            $display("unexpected wait: expected 1, seen %b", s);
            tally_and_finish();
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input int d);
        @(posedge pclk);
        t_bus <= {2'h2, w, a, 32'(d)};
        @(posedge pclk);
        t_bus[41] <= 1'b1;
        wait_hi(pready, 20);
        r = prdata;
        e = pslverr;
        t_bus <= {3'h0, ~t_bus[39:0]};
    endtask
    task automatic t_reset;
        apb(0, ADDR_LENGTH, 0);
        check("length", 32'(LEN_RESET), r);
        apb(1, 8'h40, 15);
        check("pslverr", 1, e);
        check("in request", 0, input_empty_request);
        $display("reset test done");
    endtask
    task automatic t_session(input logic [3:0] l);
        apb(1, ADDR_LENGTH, 3);
        apb(1, ADDR_TAPBASE, 0);
        apb(1, ADDR_COEFBASE, 256);
        apb(1, ADDR_IRQ_MASK, 12);
        apb(1, ADDR_CTRL, 1);
        wait_hi(input_empty_request, 8);
        lag <= l;
        go <= 1'b1;
        wait_hi(fin, 3000);
        go <= 1'b0;
        check("result 0", 32'hA, i_dma.res[0]);
        check("result 1", 32'h1A, i_dma.res[1]);
        apb(0, ADDR_DONE, 0);
        check("done", 32'h3, r);
        check("irq", 1, irq);
        apb(1, ADDR_IRQ_STAT, 15);
        apb(1, ADDR_DONE, 3);
        apb(0, ADDR_DONE, 0);
        check("done", 0, r);
        check("irq", 0, irq);
        $display("session test done");
    endtask
    task automatic t_clear;
        apb(1, ADDR_LENGTH, 0);
        apb(1, ADDR_INPUT, 5);
        apb(1, ADDR_INPUT, 6);
        apb(0, ADDR_DMA_DONE, 0);
        check("fill", 1, r);
        check("in request", 0, input_empty_request);
        check("out request", 1, output_full_request);
        apb(0, ADDR_OUTPUT, 0);
        check("result", 5, r);
        apb(1, ADDR_CTRL, 0);
        apb(1, ADDR_INPUT, 7);
        apb(0, ADDR_DMA_DONE, 0);
        check("fill", 0, r);
        check("out request", 0, output_full_request);
        check("in request", 0, input_empty_request);
        $display("clear test done");
    endtask
    initial begin
        presetn = 1'b0;
        go = 1'b0;
        lag = 4'h0;
        t_bus = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_reset();
        t_session(4'h1);
        t_clear();
        t_session(4'h4);
        tally_and_finish();
    end
endmodule // fcd_top_test
bind fcd_top fcd_checker i_chk (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .pwdata, .prdata, .pready, .pslverr, .input_empty_request,
    .output_full_request);
